// >>> verilog/tcpwm_pkg.sv
// Constants and types shared by the timer/counter/PWM design files
// Assumes nothing beyond a SystemVerilog compiler
package tcpwm_pkg;

   localparam int          TCPWM_CNT_W    = 16;
   localparam int          TCPWM_DB_W     = 8;
   localparam int          TCPWM_SRC_N    = 4;
   localparam int          TCPWM_SRC_W    = 2;
   localparam logic [15:0] TCPWM_CNT_RST  = 16'h0000;
   localparam logic [15:0] TCPWM_CAP_RST  = 16'h0000;
   localparam logic [15:0] TCPWM_ZERO     = 16'h0000;
   localparam logic [7:0]  TCPWM_DB_ZERO  = 8'h00;
   // Source index that ticks on every mclk edge
   localparam logic [1:0]  TCPWM_SRC_MCLK = 2'h0;

   typedef enum logic [1:0]
   {
      TCPWM_MODE_FREE    = 2'b00,
      TCPWM_MODE_ONESHOT = 2'b01,
      TCPWM_MODE_GATED   = 2'b10
   } tcpwm_mode_t;

   typedef enum logic [2:0]
   {
      cmp_less_than       = 3'b000,
      cmp_less_or_same    = 3'b001,
      cmp_same_value      = 3'b010,
      cmp_greater_or_same = 3'b011,
      cmp_greater_than    = 3'b100
   } tcpwm_cmp_t;

   typedef enum logic [1:0]
   {
      TCPWM_DB_LOW   = 2'b00,
      TCPWM_DB_WAITP = 2'b01,
      TCPWM_DB_HIGH  = 2'b10,
      TCPWM_DB_WAITN = 2'b11
   } tcpwm_db_st_t;

endpackage : tcpwm_pkg

// >>> verilog/tcpwm_db_if.sv
// Interface between the counter core and its deadband generator
// Assumes both ends share mclk
`timescale 1ns/1ns
interface tcpwm_db_if;
   import tcpwm_pkg::*;

   logic                  pwm_raw;
   logic                  kill;
   logic                  comp_en;
   logic [TCPWM_DB_W-1:0] dead;
   logic                  pwm_pos;
   logic                  pwm_neg;

   modport core
   (
      output pwm_raw,
      output kill,
      output comp_en,
      output dead,
      input  pwm_pos,
      input  pwm_neg
   );

   modport gen
   (
      input  pwm_raw,
      input  kill,
      input  comp_en,
      input  dead,
      output pwm_pos,
      output pwm_neg
   );

endinterface : tcpwm_db_if

// >>> verilog/tcpwm_deadband.sv
// Complementary PWM pair with deadband and kill
// Assumes pwm_raw is registered and synchronous to mclk
`timescale 1ns/1ns
module tcpwm_deadband
   import tcpwm_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   tcpwm_db_if.gen   dbi
);

   tcpwm_db_st_t          st_r;
   logic [TCPWM_DB_W-1:0] dcnt_r;
   logic                  pos_r;
   logic                  neg_r;

   ////////////////////////////////////////////////////////////////////////
   // Both outputs go low for dead+1 cycles at every edge of the raw PWM
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_r   <= TCPWM_DB_LOW;
         dcnt_r <= TCPWM_DB_ZERO;
      end
      else
      begin
         case (st_r)
            TCPWM_DB_LOW:
            begin
               if (dbi.pwm_raw)
               begin
                  st_r   <= TCPWM_DB_WAITP;
                  dcnt_r <= dbi.dead;
               end
            end
            TCPWM_DB_WAITP, TCPWM_DB_WAITN:
            begin
               // A reversal mid-gap restarts the gap the other way
               if (dbi.pwm_raw != (st_r == TCPWM_DB_WAITP))
               begin
                  st_r   <= (st_r == TCPWM_DB_WAITP) ? TCPWM_DB_WAITN
                                                     : TCPWM_DB_WAITP;
                  dcnt_r <= dbi.dead;
               end
               else if (dcnt_r == TCPWM_DB_ZERO)
                  st_r <= (st_r == TCPWM_DB_WAITP) ? TCPWM_DB_HIGH
                                                   : TCPWM_DB_LOW;
               else
                  dcnt_r <= dcnt_r - 8'h01;
            end
            TCPWM_DB_HIGH:
            begin
               if (!dbi.pwm_raw)
               begin
                  st_r   <= TCPWM_DB_WAITN;
                  dcnt_r <= dbi.dead;
               end
            end
            default:
            begin
               st_r   <= TCPWM_DB_LOW;
               dcnt_r <= TCPWM_DB_ZERO;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Kill wins over everything so a fault parks both switches off
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         pos_r <= 1'b0;
         neg_r <= 1'b0;
      end
      else
      begin
         pos_r <= !dbi.kill && (st_r == TCPWM_DB_HIGH);
         neg_r <= !dbi.kill && dbi.comp_en
                  && (st_r == TCPWM_DB_LOW);
      end
   end

   assign dbi.pwm_pos = pos_r;
   assign dbi.pwm_neg = neg_r;

endmodule : tcpwm_deadband

// >>> verilog/tcpwm_top.sv
// One 16-bit down-counting timer/counter/PWM channel
// Assumes all inputs synchronous to mclk; configuration held static
// while running. Instantiate four times for the full peripheral.
// Clock sources arrive as levels from routed logic already in the mclk
// domain; nothing here synchronises them.
//
// What this block does
// - Sixteen-bit counter, decrement only
// - Compare, terminal count, optional complement outputs
// - Free run, one shot, enable-gated modes
// - Reset, capture inputs; kill forces PWM inactive
// - Capture latches all sixteen counter bits
// - Compare relation selectable among five kinds
// - Reload period on start, reset, terminal count
// - Gated mode counts only while enable high
// - One shot stops after one period
// - Complementary outputs separated by deadband
// - Counting clock selected from several sources
`timescale 1ns/1ns
module tcpwm_top
   import tcpwm_pkg::*;
#(
   parameter int CNT_W = TCPWM_CNT_W,
   parameter int SRC_N = TCPWM_SRC_N
)
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic [SRC_N-1:0]       clk_src,
   input  wire logic [TCPWM_SRC_W-1:0] clk_sel,
   input  wire logic [1:0]             run_mode,
   input  wire logic [2:0]             cmp_sel,
   input  wire logic                   comp_en,
   input  wire logic [TCPWM_DB_W-1:0]  dead_cycles,
   input  wire logic [CNT_W-1:0]       period,
   input  wire logic [CNT_W-1:0]       compare,
   input  wire logic                   start,
   input  wire logic                   cnt_reset,
   input  wire logic                   capture,
   input  wire logic                   enable_in,
   input  wire logic                   kill,
   output logic                        cmp_out,
   output logic                        cmp_n_out,
   output logic                        tc_out,
   output logic                        running,
   output logic [CNT_W-1:0]            count_val,
   output logic [CNT_W-1:0]            capture_val
);

   ////////////////////////////////////////////////////////////////////////
   // Compare relation, applied to the registered count

   function automatic logic cmp_hit
   (
      input logic [CNT_W-1:0] cnt,
      input logic [CNT_W-1:0] ref_v,
      input logic [2:0]       sel
   );
      logic hit;
      hit = 1'b0;
      case (sel)
         cmp_less_than:       hit = cnt <  ref_v;
         cmp_less_or_same:    hit = cnt <= ref_v;
         cmp_same_value:      hit = cnt == ref_v;
         cmp_greater_or_same: hit = cnt >= ref_v;
         cmp_greater_than:    hit = cnt >  ref_v;
         default:             hit = 1'b0;
      endcase
      return hit;
   endfunction : cmp_hit

   // Mode decode for the run logic
   function automatic logic mode_oneshot
   (
      input logic [1:0] mode
   );
      return mode == TCPWM_MODE_ONESHOT;
   endfunction : mode_oneshot

   // Counter state

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [CNT_W-1:0] cap_r;
   logic [CNT_W-1:0] cap_nxt;
   logic             run_r;
   logic             run_nxt;
   logic             tc_r;
   logic             tc_nxt;
   logic             pwm_r;
   logic             pwm_nxt;

   // Edge and tick decode

   logic             start_prev_r;
   logic             cap_prev_r;
   logic [SRC_N-1:0] src_rise;
   logic             tick;
   logic             start_rise;
   logic             cap_rise;
   logic             advance;
   logic             at_zero;
   genvar            gi;

   tcpwm_db_if dbi ();

   ////////////////////////////////////////////////////////////////////////
   // Clock source selection. Sources are sampled levels: a rising edge of
   // the chosen one is a counting tick, so a source can run at most at
   // half the mclk rate. Index zero ticks on every mclk edge instead.
   // Each source keeps its own edge detector, so moving clk_sel cannot
   // fake a tick from the level that the old source had.

   generate
      for (gi = 0; gi < SRC_N; gi++)
      begin : g_src
         logic prev_r;

         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               prev_r <= 1'b0;
            else
               prev_r <= clk_src[gi];
         end

         assign src_rise[gi] = clk_src[gi] && !prev_r;
      end
   endgenerate

   assign tick = (clk_sel == TCPWM_SRC_MCLK)
                 || src_rise[clk_sel];

   ////////////////////////////////////////////////////////////////////////
   // Start and capture act on rising edges of their levels

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         start_prev_r <= 1'b0;
      else
         start_prev_r <= start;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cap_prev_r <= 1'b0;
      else
         cap_prev_r <= capture;
   end

   assign start_rise = start && !start_prev_r;
   assign cap_rise   = capture && !cap_prev_r;
   assign at_zero    = (cnt_r == TCPWM_ZERO);

   // Gated mode only moves on ticks with enable high
   always_comb
   begin
      advance = 1'b0;
      if (run_r && tick)
      begin
         case (run_mode)
            TCPWM_MODE_GATED:
               advance = enable_in;
            default:
               advance = 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Run state. Dropping start stops the counter where it stands.
   // One shot clears run on the reload tick, so the count rests at period.

   always_comb
   begin
      run_nxt = run_r;
      if (!start)
         run_nxt = 1'b0;
      else if (start_rise)
         run_nxt = 1'b1;
      else if (advance && at_zero && mode_oneshot(run_mode))
         run_nxt = 1'b0;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         run_r <= 1'b0;
      else
         run_r <= run_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter. Reset input and start share one reload, which beats counting.
   // Reload lands on the tick after zero: period+1 ticks make a cycle.

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (cnt_reset || start_rise)
         cnt_nxt = period;
      else if (advance)
      begin
         if (at_zero)
            cnt_nxt = period;
         else
            cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cnt_r <= TCPWM_CNT_RST;
      else
         cnt_r <= cnt_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Terminal count: one mclk pulse on the tick that lands on zero.
   // It stays one mclk wide even with a slow source, so downstream
   // logic sees an event rather than a level.

   always_comb
   begin
      tc_nxt = 1'b0;
      if (advance && !at_zero && !cnt_reset)
         tc_nxt = (cnt_nxt == TCPWM_ZERO);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         tc_r <= 1'b0;
      else
         tc_r <= tc_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture holds the whole count, not just a low byte

   always_comb
   begin
      cap_nxt = cap_r;
      if (cap_rise)
         cap_nxt = cnt_r;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cap_r <= TCPWM_CAP_RST;
      else
         cap_r <= cap_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparator on the registered count; kill clamps it low.
   // Comparing the registered count costs a cycle of lag but keeps the
   // compare off the decrement path.

   always_comb
   begin
      pwm_nxt = 1'b0;
      if (!kill)
         pwm_nxt = cmp_hit(cnt_r, compare, cmp_sel);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pwm_r <= 1'b0;
      else
         pwm_r <= pwm_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Deadband stage and its wiring

   assign dbi.pwm_raw = pwm_r;
   assign dbi.kill    = kill;
   assign dbi.comp_en = comp_en;
   assign dbi.dead    = dead_cycles;

   tcpwm_deadband u_db
   (
      .mclk (mclk),
      .rst  (rst),
      .dbi  (dbi)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all from flip-flops. Count and capture are plain
   // registers, so reading them never disturbs counting.

   assign cmp_out     = dbi.pwm_pos;
   assign cmp_n_out   = dbi.pwm_neg;
   assign tc_out      = tc_r;
   assign running     = run_r;
   assign count_val   = cnt_r;
   assign capture_val = cap_r;

endmodule : tcpwm_top

// >>> testbench/tcpwm_assertions.sv
// Port checker for one timer channel
// Assumes it is bound onto tcpwm_top, single mclk domain
`timescale 1ns/1ns
module tcpwm_assertions
   import tcpwm_pkg::*;
#(
   parameter int CNT_W = TCPWM_CNT_W,
   parameter int SRC_N = TCPWM_SRC_N
)
(
   input wire logic                   mclk,
   input wire logic                   rst,
   input wire logic [TCPWM_SRC_W-1:0] clk_sel,
   input wire logic [1:0]             run_mode,
   input wire logic                   comp_en,
   input wire logic [CNT_W-1:0]       period,
   input wire logic                   start,
   input wire logic                   cnt_reset,
   input wire logic                   capture,
   input wire logic                   enable_in,
   input wire logic                   kill,
   input wire logic                   cmp_out,
   input wire logic                   cmp_n_out,
   input wire logic                   tc_out,
   input wire logic                   running,
   input wire logic [CNT_W-1:0]       count_val,
   input wire logic [CNT_W-1:0]       capture_val
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_live;
      running && !cnt_reset;
   endsequence
   sequence s_kill2;
      kill [*2];
   endsequence
   AST_DOWN: assert property (
      s_live ##1 count_val != $past(count_val) |->
      count_val == $past(count_val) - 1 || count_val == period)
      else $error("Count moved up");
   AST_TC_ZERO: assert property (tc_out |-> count_val == 0)
      else $error("Terminal count off zero");
   AST_TC_ONE: assert property (
      tc_out && period != 0 |=> !tc_out)
      else $error("Terminal count too long");
   AST_RST_LOAD: assert property (
      cnt_reset |=> count_val == $past(period))
      else $error("Reset did not reload");
   AST_START: assert property (
      $rose(start) && !cnt_reset |=> running && count_val == $past(period))
      else $error("Start did not load");
   AST_CAP: assert property (
      $rose(capture) |=> capture_val == $past(count_val))
      else $error("Capture wrong");
   AST_GATE: assert property (
      run_mode == 2'h2 && !enable_in && !cnt_reset && !$rose(start)
      |=> $stable(count_val))
      else $error("Gated count moved");
   AST_KILL: assert property (
      s_kill2 |=> !cmp_out && !cmp_n_out)
      else $error("Kill ignored");
   AST_PAIR: assert property (!(cmp_out && cmp_n_out))
      else $error("Both outputs active");
   AST_NEG: assert property ((!comp_en) [*2] |=> !cmp_n_out)
      else $error("Complement while off");
   AST_ONE: assert property (
      run_mode == 2'h1 && clk_sel == TCPWM_SRC_MCLK && tc_out && !cnt_reset
      && $stable(start) |=> !running || $rose(start))
      else $error("One shot kept running");
endmodule : tcpwm_assertions

bind tcpwm_top tcpwm_assertions #(.CNT_W(CNT_W), .SRC_N(SRC_N)) chk_u (
   .mclk(mclk), .rst(rst), .clk_sel(clk_sel), .run_mode(run_mode),
   .comp_en(comp_en), .period(period), .start(start),
   .cnt_reset(cnt_reset), .capture(capture), .enable_in(enable_in),
   .kill(kill), .cmp_out(cmp_out), .cmp_n_out(cmp_n_out),
   .tc_out(tc_out), .running(running), .count_val(count_val),
   .capture_val(capture_val));

// >>> testbench/tcpwm_src_model.sv
// Routed clock sources that feed the channel
// Assumes mclk runs free; each source is a divided copy of it
`timescale 1ns/1ns
module tcpwm_src_model
   import tcpwm_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst,
   output logic [TCPWM_SRC_N-1:0] clk_src
);
   logic [TCPWM_SRC_N-1:0] div_r;
   // Bit k rises every 2**(k+1) mclk; bit 0 is ignored by the channel
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         div_r <= 4'h0;
      else
         div_r <= div_r + 4'h1;
   end
   assign clk_src = div_r;
endmodule : tcpwm_src_model

// >>> testbench/tb_top.sv
// Self-checking bench for one timer channel
// Assumes tcpwm_top, the source model and the bound checker
`timescale 1ns/1ns
module tb_top;
   import tcpwm_pkg::*;
   logic mclk = 1'b0, rst = 1'b1;
   logic [3:0] clk_src;
   logic [1:0] clk_sel = 2'h0, run_mode = 2'h0;
   logic [2:0] cmp_sel = 3'h0;
   logic [7:0] dead_cycles = 8'h00;
   logic [15:0] period = 16'h0000, compare = 16'h0000;
   logic comp_en = 1'b1, start = 1'b0, cnt_reset = 1'b0, capture = 1'b0;
   logic enable_in = 1'b0, kill = 1'b0;
   logic cmp_out, cmp_n_out, tc_out, running;
   logic [15:0] count_val, capture_val;
   int err_count = 0, checked = 0, n = 0;
   always #10 mclk = ~mclk;
   tcpwm_src_model src_u (.mclk(mclk), .rst(rst), .clk_src(clk_src));
   tcpwm_top dut_u (.mclk(mclk), .rst(rst), .clk_src(clk_src),
      .clk_sel(clk_sel), .run_mode(run_mode), .cmp_sel(cmp_sel),
      .comp_en(comp_en), .dead_cycles(dead_cycles), .period(period),
      .compare(compare), .start(start), .cnt_reset(cnt_reset),
      .capture(capture), .enable_in(enable_in), .kill(kill),
      .cmp_out(cmp_out), .cmp_n_out(cmp_n_out), .tc_out(tc_out),
      .running(running), .count_val(count_val), .capture_val(capture_val));
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask : cyc
   // Start is lowered first so every test sees a fresh rising edge
   task automatic go(input logic [1:0] m, input logic [1:0] s,
                     input logic [15:0] p);
      run_mode = m;
      clk_sel = s;
      period = p;
      start = 1'b0;
      cyc(1);
      start = 1'b1;
      cyc(1);
   endtask : go
   task automatic wait_tc;
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end while (tc_out !== 1'b1 && n < 300);
      if (n >= 300)
      begin
         err_count++;
         $display("[ERR] %0t no terminal count", $time);
      end
   endtask : wait_tc
   function automatic logic rel(input logic [2:0] s, input logic [15:0] c);
      case (s)
         cmp_less_than:       rel = 16'h0005 < c;
         cmp_less_or_same:    rel = 16'h0005 <= c;
         cmp_same_value:      rel = 16'h0005 == c;
         cmp_greater_or_same: rel = 16'h0005 >= c;
         cmp_greater_than:    rel = 16'h0005 > c;
         default:             rel = 1'b0;
      endcase
   endfunction : rel
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #400000;
      err_count++;
      wrap_up();
   end
   initial
   begin
      cyc(20);
      rst = 1'b0;
      go(2'h1, 2'h0, 16'h0002);
      chk(count_val, 16'h0002);
      chk(16'(running), 16'h0001);
      cyc(1);
      chk(count_val, 16'h0001);
      cyc(1);
      chk(16'(tc_out), 16'h0001);
      cyc(1);
      chk(count_val, 16'h0002);
      chk(16'(running), 16'h0000);
      $display("Test one shot done");
      go(2'h0, 2'h1, 16'h0003);
      wait_tc();
      wait_tc();
      chk(16'(n), 16'h0010);
      $display("Test clock source done");
      go(2'h0, 2'h0, 16'hfedc);
      cyc(9);
      chk(count_val, 16'hfed3);
      capture = 1'b1;
      cyc(1);
      chk(capture_val, 16'hfed3);
      capture = 1'b0;
      cnt_reset = 1'b1;
      cyc(2);
      chk(count_val, 16'hfedc);
      cnt_reset = 1'b0;
      cyc(2);
      chk(count_val, 16'hfeda);
      $display("Test capture and reset done");
      go(2'h2, 2'h0, 16'h0064);
      enable_in = 1'b1;
      cyc(3);
      chk(count_val, 16'h0061);
      enable_in = 1'b0;
      cyc(3);
      chk(count_val, 16'h0061);
      $display("Test gated done");
      go(2'h2, 2'h0, 16'h0005);
      for (int s = 0; s < 6; s++)
         for (int c = 4; c < 7; c++)
         begin
            cmp_sel = 3'(s);
            compare = 16'(c);
            cyc(8);
            chk(16'(cmp_out), 16'(rel(cmp_sel, compare)));
            chk(16'(cmp_n_out), 16'(!rel(cmp_sel, compare)));
         end
      dead_cycles = 8'h03;
      cmp_sel = 3'h0;
      cyc(3);
      chk(16'({cmp_out, cmp_n_out}), 16'h0000);
      cyc(3);
      chk(16'(cmp_out), 16'h0000);
      cyc(1);
      chk(16'(cmp_out), 16'h0001);
      kill = 1'b1;
      cyc(3);
      chk(16'({cmp_out, cmp_n_out}), 16'h0000);
      kill = 1'b0;
      comp_en = 1'b0;
      compare = 16'h0004;
      cyc(8);
      chk(16'({cmp_out, cmp_n_out}), 16'h0000);
      comp_en = 1'b1;
      cyc(1);
      chk(16'(cmp_n_out), 16'h0001);
      kill = 1'b1;
      cyc(1);
      chk(16'(cmp_n_out), 16'h0000);
      kill = 1'b0;
      $display("Test compare done");
      wrap_up();
   end
endmodule : tb_top
